// ---- pkg/sfdl_pkg.sv ----
// Shared constants and types for the supply fault detector logic
package sfdl_pkg;
  // Detector bank shape: 0..1 bipolar, 2 high voltage, 3..6 positive only
  localparam int NUM_DET = 7;
  localparam int NUM_BIP = 2;
  localparam int HV_DET = 2;
  localparam int CODE_W = 8;
  localparam int HYST_W = 5;
  localparam int IDX_W = 8;
  localparam int GF_CNT_W = 16;

  // Register indices; byte address on the bus is four times the index
  localparam logic [IDX_W-1:0] DET_BASE_IDX = 8'ha0;
  localparam logic [IDX_W-1:0] DET_STRIDE = 8'h08;
  localparam logic [2:0] OFS_OVTH = 3'h0;
  localparam logic [2:0] OFS_OVHY = 3'h1;
  localparam logic [2:0] OFS_UVTH = 3'h2;
  localparam logic [2:0] OFS_UVHY = 3'h3;
  localparam logic [2:0] OFS_SEL = 3'h4;
  localparam logic [IDX_W-1:0] FILT_STATUS_IDX = 8'he0;
  localparam logic [IDX_W-1:0] RAW_STATUS_IDX = 8'he1;

  // Select register field layout
  localparam int SEL_FT_LSB = 0;
  localparam int SEL_RANGE_LSB = 2;
  localparam int SEL_GF_LSB = 4;
  localparam int SEL_POL_BIT = 7;

  // Power-on values
  localparam logic [CODE_W-1:0] OVTH_RST = 8'hff;
  localparam logic [CODE_W-1:0] UVTH_RST = 8'h00;
  localparam logic [HYST_W-1:0] HYST_RST = 5'h00;
  localparam logic [CODE_W-1:0] SEL_RST = 8'h00;
  localparam logic [CODE_W-1:0] CODE_MAX = 8'hff;

  // Glitch filter timing: delays are whole multiples of a 5 us step
  localparam int CLK_MHZ = 200;
  localparam int GF_STEP_NS = 5000;
  localparam int GF_STEP_CYC = (GF_STEP_NS * CLK_MHZ) / 1000;
  localparam int GF_MAX_STEPS = 20;

  // Fault type select codes
  typedef enum logic [1:0] {
    FT_UNDER = 2'b00,
    FT_OVER = 2'b01,
    FT_WINDOW = 2'b10,
    FT_WINDOW_ALT = 2'b11
  } sfdl_fault_e;

  // Range codes handed to the analog divider
  typedef enum logic [2:0] {
    RNG_FIELD0 = 3'b000,
    RNG_FIELD1 = 3'b001,
    RNG_FIELD2 = 3'b010,
    RNG_FIELD3 = 3'b011,
    RNG_NEGATIVE = 3'b100
  } sfdl_range_e;

  // Glitch delay field to number of 5 us steps
  function automatic logic [4:0] gf_steps(input logic [2:0] code);
    logic [4:0] s;
    s = 5'h00;
    case (code)
      3'h0: s = 5'h00;
      3'h1: s = 5'h01;
      3'h2: s = 5'h02;
      3'h3: s = 5'h04;
      3'h4: s = 5'h08;
      3'h5: s = 5'h0c;
      3'h6: s = 5'h10;
      3'h7: s = 5'(GF_MAX_STEPS);
      default: s = 5'h00;
    endcase
    return s;
  endfunction
endpackage

// ---- pkg/sfdl_gf_if.sv ----
// Carrier between a detector and its glitch filter
`timescale 1ns/10ps
interface sfdl_gf_if;
  logic raw_fault; // Unfiltered selected fault
  logic [sfdl_pkg::GF_CNT_W-1:0] delay_cyc; // Programmed timeout in clocks
  logic filt_fault; // Filtered fault
  modport det (output raw_fault, output delay_cyc, input filt_fault);
  modport filt (input raw_fault, input delay_cyc, output filt_fault);
endinterface

// ---- hdl/sfdl_glitch_filter.sv ----
// Glitch filter: passes a level only after it has held for the timeout
`timescale 1ns/10ps
module sfdl_glitch_filter (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Detector side
  sfdl_gf_if.filt gf
);
  logic out_reg; // Filtered level
  logic out_next;
  logic [sfdl_pkg::GF_CNT_W-1:0] cnt_reg; // Cycles the input has differed
  logic [sfdl_pkg::GF_CNT_W-1:0] cnt_next;

  // Count while input differs from output; a return to the old level restarts
  always_comb begin
    out_next = out_reg;
    cnt_next = '0;
    if (gf.raw_fault != out_reg) begin
      // Zero delay still takes one clock, which keeps the output registered
      if (cnt_reg + 1'b1 >= gf.delay_cyc) begin
        out_next = gf.raw_fault;
        cnt_next = '0;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end else begin
      cnt_next = '0; // Short pulse dropped
    end
  end

  // State registers, frozen while the enable is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_reg <= 1'b0;
      cnt_reg <= '0;
    end else if (ce) begin
      out_reg <= out_next;
      cnt_reg <= cnt_next;
    end
  end

  assign gf.filt_fault = out_reg;
endmodule

// ---- hdl/sfdl_top.sv ----
// Supply fault detector bank: registers, hysteresis, fault select, filters
//
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/10ps
module sfdl_top #(
  parameter int GF_STEP_CYCLES = sfdl_pkg::GF_STEP_CYC
) (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Analog comparator results, high when that side is violated
  input wire logic [sfdl_pkg::NUM_DET-1:0] uv_cmp,
  input wire logic [sfdl_pkg::NUM_DET-1:0] ov_cmp,
  // Codes and range steering for the threshold converters
  output logic [sfdl_pkg::NUM_DET-1:0][7:0] uv_dac_code,
  output logic [sfdl_pkg::NUM_DET-1:0][7:0] ov_dac_code,
  output logic [sfdl_pkg::NUM_DET-1:0][2:0] range_code,
  // Filtered fault per detector
  output logic [sfdl_pkg::NUM_DET-1:0] fault_out
);
  localparam int N = sfdl_pkg::NUM_DET;
  localparam int CW = sfdl_pkg::CODE_W;
  localparam int HW = sfdl_pkg::HYST_W;
  localparam int IW = sfdl_pkg::IDX_W;

  // Bus pipeline state
  logic wr_pend_reg; // Write data phase pending
  logic wr_pend_next;
  logic [IW-1:0] idx_reg; // Index latched in the address phase
  logic [IW-1:0] idx_next;
  logic [31:0] hrdata_reg; // Read data, loaded in the address phase
  logic [31:0] hrdata_next;

  // Per detector configuration
  logic [CW-1:0] ovth_reg [N];
  logic [CW-1:0] ovth_next [N];
  logic [HW-1:0] ovhy_reg [N];
  logic [HW-1:0] ovhy_next [N];
  logic [CW-1:0] uvth_reg [N];
  logic [CW-1:0] uvth_next [N];
  logic [HW-1:0] uvhy_reg [N];
  logic [HW-1:0] uvhy_next [N];
  logic [CW-1:0] sel_reg [N];
  logic [CW-1:0] sel_next [N];

  // Detector state
  logic [N-1:0] uv_state_reg; // Undervoltage currently asserted
  logic [N-1:0] uv_state_next;
  logic [N-1:0] ov_state_reg; // Overvoltage currently asserted
  logic [N-1:0] ov_state_next;
  logic [N-1:0][7:0] uv_dac_reg;
  logic [N-1:0][7:0] uv_dac_next;
  logic [N-1:0][7:0] ov_dac_reg;
  logic [N-1:0][7:0] ov_dac_next;
  logic [N-1:0][2:0] range_reg;
  logic [N-1:0][2:0] range_next;
  logic [N-1:0] raw_fault; // Selected fault before filtering
  logic [N-1:0] filt_fault; // Filter outputs

  logic acc; // Address phase accepted this cycle
  logic in_map; // Upper address bits clear

  // Register index of one detector's register
  function automatic logic [IW-1:0] det_idx(input int d, input logic [2:0] ofs);
    logic [IW-1:0] base;
    base = sfdl_pkg::DET_BASE_IDX + IW'(d) * sfdl_pkg::DET_STRIDE;
    return base + {{(IW-3){1'b0}}, ofs};
  endfunction

  // Read multiplexer; reserved bits and unmapped indices read as zero
  function automatic logic [31:0] rd_mux(input logic [IW-1:0] idx);
    logic [31:0] v;
    v = 32'h0000_0000;
    for (int d = 0; d < N; d++) begin
      if (idx == det_idx(d, sfdl_pkg::OFS_OVTH)) v = {24'h000000, ovth_reg[d]};
      if (idx == det_idx(d, sfdl_pkg::OFS_OVHY)) v = {27'h0000000, ovhy_reg[d]};
      if (idx == det_idx(d, sfdl_pkg::OFS_UVTH)) v = {24'h000000, uvth_reg[d]};
      if (idx == det_idx(d, sfdl_pkg::OFS_UVHY)) v = {27'h0000000, uvhy_reg[d]};
      if (idx == det_idx(d, sfdl_pkg::OFS_SEL)) v = {24'h000000, sel_reg[d]};
    end
    if (idx == sfdl_pkg::FILT_STATUS_IDX) v = {25'h0000000, filt_fault};
    if (idx == sfdl_pkg::RAW_STATUS_IDX) v = {25'h0000000, raw_fault};
    return v;
  endfunction

  // Zero wait states while enabled; a frozen block stretches the data phase
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign in_map = (haddr[31:10] == 22'h000000);
  assign acc = hsel & htrans[1] & hready;

  // Bus pipeline and register writes
  always_comb begin
    wr_pend_next = acc & hwrite;
    idx_next = acc ? (in_map ? haddr[9:2] : 8'h00) : idx_reg;
    hrdata_next = hrdata_reg;
    if (acc && !hwrite) begin
      hrdata_next = in_map ? rd_mux(haddr[9:2]) : 32'h0000_0000;
    end
    for (int d = 0; d < N; d++) begin
      ovth_next[d] = ovth_reg[d];
      ovhy_next[d] = ovhy_reg[d];
      uvth_next[d] = uvth_reg[d];
      uvhy_next[d] = uvhy_reg[d];
      sel_next[d] = sel_reg[d];
      if (wr_pend_reg) begin
        if (idx_reg == det_idx(d, sfdl_pkg::OFS_OVTH)) ovth_next[d] = hwdata[7:0];
        if (idx_reg == det_idx(d, sfdl_pkg::OFS_UVTH)) uvth_next[d] = hwdata[7:0];
        // Only the five low bits of a hysteresis register hold state
        if (idx_reg == det_idx(d, sfdl_pkg::OFS_OVHY)) ovhy_next[d] = hwdata[4:0];
        if (idx_reg == det_idx(d, sfdl_pkg::OFS_UVHY)) uvhy_next[d] = hwdata[4:0];
        if (idx_reg == det_idx(d, sfdl_pkg::OFS_SEL)) begin
          sel_next[d] = hwdata[7:0];
          // Polarity exists only on bipolar detectors; elsewhere it stays zero
          if (d >= sfdl_pkg::NUM_BIP) begin
            sel_next[d][sfdl_pkg::SEL_POL_BIT] = 1'b0;
          end
        end
      end
    end
  end

  // Bus and configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      idx_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
      for (int d = 0; d < N; d++) begin
        ovth_reg[d] <= sfdl_pkg::OVTH_RST;
        ovhy_reg[d] <= sfdl_pkg::HYST_RST;
        uvth_reg[d] <= sfdl_pkg::UVTH_RST;
        uvhy_reg[d] <= sfdl_pkg::HYST_RST;
        sel_reg[d] <= sfdl_pkg::SEL_RST;
      end
    end else if (ce) begin
      wr_pend_reg <= wr_pend_next;
      idx_reg <= idx_next;
      hrdata_reg <= hrdata_next;
      for (int d = 0; d < N; d++) begin
        ovth_reg[d] <= ovth_next[d];
        ovhy_reg[d] <= ovhy_next[d];
        uvth_reg[d] <= uvth_next[d];
        uvhy_reg[d] <= uvhy_next[d];
        sel_reg[d] <= sel_next[d];
      end
    end
  end

  // Hysteresis and range steering for every detector
  always_comb begin
    logic [8:0] up;
    logic [8:0] dn;
    up = 9'h000;
    dn = 9'h000;
    for (int d = 0; d < N; d++) begin
      // The comparator sees the currently applied level, so its output is the fault
      uv_state_next[d] = uv_cmp[d];
      ov_state_next[d] = ov_cmp[d];
      // Hysteresis shares the threshold step, so codes simply add on the undervoltage side and subtract on the overvoltage side
      up = {1'b0, uvth_reg[d]} + {4'h0, uvhy_reg[d]};
      dn = {1'b0, ovth_reg[d]} - {4'h0, ovhy_reg[d]};
      // Saturate at the ends of the code range rather than wrap
      uv_dac_next[d] = uvth_reg[d];
      if (uv_state_next[d]) begin
        uv_dac_next[d] = up[8] ? sfdl_pkg::CODE_MAX : up[7:0];
      end
      ov_dac_next[d] = ovth_reg[d];
      if (ov_state_next[d]) begin
        ov_dac_next[d] = dn[8] ? 8'h00 : dn[7:0];
      end
      // The range field picks one of the overlapping one-third ranges
      range_next[d] = {1'b0, sel_reg[d][sfdl_pkg::SEL_RANGE_LSB +: 2]};
      if (d < sfdl_pkg::NUM_BIP && sel_reg[d][sfdl_pkg::SEL_POL_BIT]) begin
        range_next[d] = sfdl_pkg::RNG_NEGATIVE;
      end
    end
  end

  // Detector state registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      uv_state_reg <= '0;
      ov_state_reg <= '0;
      uv_dac_reg <= '0;
      ov_dac_reg <= {N{sfdl_pkg::OVTH_RST}};
      range_reg <= '0;
    end else if (ce) begin
      uv_state_reg <= uv_state_next;
      ov_state_reg <= ov_state_next;
      uv_dac_reg <= uv_dac_next;
      ov_dac_reg <= ov_dac_next;
      range_reg <= range_next;
    end
  end

  assign uv_dac_code = uv_dac_reg;
  assign ov_dac_code = ov_dac_reg;
  assign range_code = range_reg;
  assign fault_out = filt_fault;

  // One detector slice and glitch filter per input
  for (genvar g = 0; g < N; g++) begin : g_det
    sfdl_gf_if gf_bus ();
    logic [4:0] steps;
    logic [31:0] dly_full;

    // Fault type mux: undervoltage, overvoltage, or either of the two (both window codes) reaches the filter
    always_comb begin
      case (sfdl_pkg::sfdl_fault_e'(sel_reg[g][sfdl_pkg::SEL_FT_LSB +: 2]))
        sfdl_pkg::FT_UNDER: raw_fault[g] = uv_state_reg[g];
        sfdl_pkg::FT_OVER: raw_fault[g] = ov_state_reg[g];
        sfdl_pkg::FT_WINDOW: raw_fault[g] = uv_state_reg[g] | ov_state_reg[g];
        sfdl_pkg::FT_WINDOW_ALT: raw_fault[g] = uv_state_reg[g] | ov_state_reg[g];
        default: raw_fault[g] = 1'b0;
      endcase
    end

    // Delay field to clock count; the longest code is the 100 us ceiling
    assign steps = sfdl_pkg::gf_steps(sel_reg[g][sfdl_pkg::SEL_GF_LSB +: 3]);
    assign dly_full = 32'(steps) * 32'(GF_STEP_CYCLES);
    assign gf_bus.raw_fault = raw_fault[g];
    assign gf_bus.delay_cyc = dly_full[sfdl_pkg::GF_CNT_W-1:0];
    assign filt_fault[g] = gf_bus.filt_fault;

    // Filter is the final stage before the fault output
    sfdl_glitch_filter u_gf (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .gf(gf_bus.filt)
    );
  end
endmodule

// ---- bench/sfdl_rail_model.sv ----
// Comparator model of the monitored supply rails
`timescale 1ns/10ps
module sfdl_rail_model (
  // Clock
  input wire logic hclk,
  // Rail levels as codes, and the codes the block applies
  input wire logic [6:0][7:0] level,
  input wire logic [6:0][7:0] uv_code,
  input wire logic [6:0][7:0] ov_code,
  // Comparator results, high when that side is violated
  output logic [6:0] uv_cmp,
  output logic [6:0] ov_cmp
);
  // Known at time zero so the block never samples an unknown
  initial {uv_cmp, ov_cmp} = '0;
  // Sampled once a clock, as a comparator behind a synchroniser would be
  always @(posedge hclk) begin
    for (int d = 0; d < 7; d++) begin
      uv_cmp[d] <= level[d] < uv_code[d];
      ov_cmp[d] <= level[d] > ov_code[d];
    end
  end
endmodule

// ---- bench/sfdl_top_assertions.sv ----
// Port-level assertions for the supply fault detector bank
`timescale 1ns/10ps
module sfdl_top_assertions #(
  parameter int GF_STEP_CYCLES = 4
) (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Detector side
  input wire logic [sfdl_pkg::NUM_DET-1:0] uv_cmp,
  input wire logic [sfdl_pkg::NUM_DET-1:0] ov_cmp,
  input wire logic [sfdl_pkg::NUM_DET-1:0][7:0] uv_dac_code,
  input wire logic [sfdl_pkg::NUM_DET-1:0][7:0] ov_dac_code,
  input wire logic [sfdl_pkg::NUM_DET-1:0][2:0] range_code,
  input wire logic [sfdl_pkg::NUM_DET-1:0] fault_out
);
  // One clock domain, so clocking and disable are given once
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not OKAY");
  chk_ready_ce: assert property (hreadyout == ce)
    else $error("hreadyout differs from ce");
  // Read data may only move when a read address phase is taken
  chk_rdata_hold: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
    else $error("hrdata moved without a read");
  chk_reset_vals: assert property ($rose(hresetn) |-> fault_out == '0 && range_code == '0 &&
    uv_dac_code == '0 && ov_dac_code == '1)
    else $error("outputs not at power-on values");
  // Per detector: hysteresis direction and filter cause and latency
  for (genvar d = 0; d < sfdl_pkg::NUM_DET; d++) begin : g_det
    if (d >= sfdl_pkg::NUM_BIP) begin : g_pos
      chk_neg_range: assert property (range_code[d][2] == 1'b0)
        else $error("negative range on a positive detector");
    end
    chk_uv_hyst: assert property ($rose(uv_cmp[d]) |=> uv_dac_code[d] >= $past(uv_dac_code[d]))
      else $error("undervoltage level dropped on fault");
    chk_fault_cause: assert property ($rose(fault_out[d]) |->
      $past(uv_cmp[d] | ov_cmp[d], 2) || $past(uv_cmp[d] | ov_cmp[d], 3))
      else $error("fault passed without a comparator fault");
    chk_min_delay: assert property ($rose(uv_cmp[d] | ov_cmp[d]) && !fault_out[d] |=>
      !fault_out[d])
      else $error("fault passed the filter at once");
  end
endmodule
bind sfdl_top sfdl_top_assertions #(.GF_STEP_CYCLES(GF_STEP_CYCLES)) sfdl_top_assertions_inst (
  .hclk, .hresetn, .ce, .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
  .uv_cmp, .ov_cmp, .uv_dac_code, .ov_dac_code, .range_code, .fault_out);

// ---- bench/sfdl_top_tb.sv ----
// Self-checking testbench for the supply fault detector bank
`timescale 1ns/10ps
module sfdl_top_tb;
  // Short filter step keeps delays to a few clocks
  localparam int STEP = 4;
  localparam logic [7:0] RAW = sfdl_pkg::RAW_STATUS_IDX;
  localparam logic [7:0] FILT = sfdl_pkg::FILT_STATUS_IDX;
  // Clock, reset, enable and bus master
  logic hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp;
  // Detector side; level is each rail as a code
  logic [6:0] uv_cmp, ov_cmp, fault_out;
  logic [6:0][7:0] level = '0, uv_dac_code, ov_dac_code;
  logic [6:0][2:0] range_code;
  // Scoreboard and scenario state
  logic [31:0] exp_q[$];
  logic rd_dp = 1'b0, uvf, ovf, f;
  logic [7:0] v, sel_v[7];
  logic [2:0] ord[5] = '{3'h1, 3'h3, 3'h0, 3'h2, 3'h4};
  int err_total = 0, comparisons = 0, n, n1, gs[3] = '{1, 2, 20};
  always #2.5 hclk = ~hclk;
  sfdl_top #(.GF_STEP_CYCLES(STEP)) sfdl_top_inst (.hclk, .hresetn, .ce, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .uv_cmp, .ov_cmp, .uv_dac_code, .ov_dac_code, .range_code, .fault_out);
  sfdl_rail_model sfdl_rail_model_inst (.hclk, .level, .uv_code(uv_dac_code),
    .ov_code(ov_dac_code), .uv_cmp, .ov_cmp);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic results();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Bounded wait for hready high at a rising edge
  task automatic wait_rdy();
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (i >= 50) begin
      err_total++;
      results();
    end
  endtask
  // One single transfer; reads note their expected word for the monitor
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d, e);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    if (!w) exp_q.push_back(e);
    wait_rdy();
  endtask
  function automatic logic [7:0] a(input int d, input int o);
    return 8'(sfdl_pkg::DET_BASE_IDX + sfdl_pkg::DET_STRIDE * d + o);
  endfunction
  // Same setup on every detector, hysteresis first, so status is all or none
  task automatic cfg(input logic [7:0] uvhy, input logic [7:0] sel);
    for (int d = 0; d < 7; d++) begin
      bus(1, a(d, 1), 0, 0);
      bus(1, a(d, 3), {24'h0, uvhy}, 0);
      bus(1, a(d, 0), 32'hc0, 0);
      bus(1, a(d, 2), 32'h40, 0);
      bus(1, a(d, 4), {24'h0, sel}, 0);
    end
  endtask
  // Compares the oldest note whenever a read data phase completes
  always @(posedge hclk) begin
    if (rd_dp && hreadyout === 1'b1) begin
      if (exp_q.size() > 0) chk(hrdata, exp_q.pop_front());
      else chk(hrdata, 32'hx);
    end
    rd_dp <= hsel && htrans[1] && hreadyout && !hwrite;
  end
  initial begin
    void'($urandom(32'hc8a9c54c));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Power-on values, then an unmapped index
    for (int d = 0; d < 7; d++) begin
      for (int o = 0; o < 5; o++) bus(0, a(d, o), 0, (o == 0) ? 32'hff : 32'h0);
    end
    bus(0, 8'h50, 0, 0);
    // Random codes; hysteresis keeps five bits, polarity set on one bipolar
    for (int d = 0; d < 7; d++) begin
      foreach (ord[k]) begin
        v = 8'($urandom);
        if (ord[k] == 3'h4) v[7] = (d == 0);
        if (ord[k] == 3'h4) sel_v[d] = v;
        bus(1, a(d, ord[k]), {24'h0, v}, 0);
        bus(0, a(d, ord[k]), 0, ord[k][0] ? {27'h0, v[4:0]} : {24'h0, v});
      end
    end
    repeat (3) @(posedge hclk);
    for (int d = 0; d < 7; d++) begin
      chk(range_code[d], (sel_v[d][7] && d < 2) ? 3'b100 : {1'b0, sel_v[d][3:2]});
    end
    // Every fault type against a rail below, inside and above the window
    for (int i = 0; i < 3; i++) begin
      for (int t = 0; t < 4; t++) begin
        level <= {7{8'(8'h20 + i * 8'h60)}};
        cfg(8'h00, 8'(t));
        uvf = i == 0;
        ovf = i == 2;
        f = (t == 0) ? uvf : (t == 1) ? ovf : (uvf | ovf);
        repeat (100) @(posedge hclk);
        bus(0, RAW, 0, f ? 32'h7f : 32'h0);
        bus(0, FILT, 0, f ? 32'h7f : 32'h0);
      end
    end
    // Undervoltage holds until the rail passes threshold plus hysteresis
    level <= {7{8'h80}};
    cfg(8'h0a, 8'h00);
    for (int i = 0; i < 3; i++) begin
      level <= {7{8'(8'h38 + i * 8'h09)}};
      repeat (8) @(posedge hclk);
      chk(uv_dac_code[3], (i < 2) ? 8'h4a : 8'h40);
      bus(0, RAW, 0, (i < 2) ? 32'h7f : 32'h0);
    end
    // Delay per glitch code; the difference from code one is exact clocks
    for (int i = 0; i < 3; i++) begin
      level <= {7{8'h80}};
      repeat (100) @(posedge hclk);
      cfg(8'h00, {1'b0, (i == 2) ? 3'h7 : 3'(i + 1), 4'h0});
      level <= {7{8'h20}};
      n = 0;
      while (fault_out[3] !== 1'b1 && n < 300) begin
        @(posedge hclk);
        n++;
      end
      if (i == 0) n1 = n;
      chk(n - n1, (gs[i] - 1) * STEP);
    end
    // Two pulses shorter than the timeout, close together, never pass
    level <= {7{8'h80}};
    repeat (100) @(posedge hclk);
    cfg(8'h00, 8'h20);
    for (int p = 0; p < 2; p++) begin
      level <= {7{8'h20}};
      repeat (5) @(posedge hclk);
      level <= {7{8'h80}};
      repeat (2) @(posedge hclk);
    end
    repeat (20) @(posedge hclk);
    bus(0, FILT, 0, 0);
    // Stall with the enable, then reset again mid-run
    ce <= 1'b0;
    repeat (3) @(posedge hclk);
    ce <= 1'b1;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(0, a(3, 0), 0, 32'hff);
    @(posedge hclk);
    results();
  end
endmodule
